// File: logic/pcs_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef PCS_MAP_VH
`define PCS_MAP_VH

// special-function register offsets
`define PCS_SLEEP_CYCLE_COUNT_ADDR   8'hC4
`define PCS_WAKE_CYCLE_COUNT_ADDR    8'hC5
`define PCS_PLL_SETUP_BYTE0_ADDR     8'hD8
`define PCS_PLL_SETUP_BYTE1_ADDR     8'hD9
`define PCS_PLL_SETUP_BYTE2_ADDR     8'hDA
`define PCS_PLL_SETUP_BYTE3_ADDR     8'hDB
`define PCS_PLL_SETUP_COMMIT_ADDR    8'hDD
`define PCS_CLOCK_STATUS_ADDR        8'hDE

// reset values
`define PCS_SLEEP_CYCLE_COUNT_RST    8'h00
`define PCS_WAKE_CYCLE_COUNT_RST     8'h00
`define PCS_PLL_BYTE_RST             8'h00

// field positions inside the 40-bit setup word
`define PCS_MULT_LSB                 0
`define PCS_MULT_MSB                 11
`define PCS_LOCK_RANGE_ONE_LSB       12
`define PCS_LOCK_RANGE_ONE_MSB       15
`define PCS_SRC_SEL_LSB              16
`define PCS_SRC_SEL_MSB              18
`define PCS_DIV_BYPASS_BIT           23
`define PCS_REF_DIV_LSB              32
`define PCS_REF_DIV_MSB              33
// wake setup field inside byte 3
`define PCS_WAKE_SETUP_LSB           3
`define PCS_WAKE_SETUP_MSB           6

// system clock source codes
`define PCS_SRC_OSC                  3'h0
`define PCS_SRC_EXT                  3'h1
`define PCS_SRC_PLL                  3'h2
`define PCS_SRC_OSC_DIV8             3'h3
`define PCS_SRC_OSC_DIV16            3'h4
`define PCS_SRC_OSC_DIV32            3'h5
`define PCS_SRC_OSC_DIV64            3'h6
`define PCS_SRC_OSC_DIV256           3'h7

// sleep length is the register value shifted left by this
`define PCS_SLEEP_SHIFT              4

// dead time between dropping one source and enabling the next
`define PCS_SWITCH_GAP_NS            32
`define PCS_CLK_PERIOD_NS            8
`define PCS_SWITCH_GAP_CYCLES \
    ((`PCS_SWITCH_GAP_NS + `PCS_CLK_PERIOD_NS - 1) / `PCS_CLK_PERIOD_NS)

`endif

// File: logic/pcs_srcsw.v
// break-before-make switch of the system clock source enables
`timescale 1ns/1ns
`include "pcs_map.vh"
module pcs_srcsw (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // requested source code
    input  wire [2:0] req_src,
    // source enables and state
    output reg  [2:0] src_en,
    output reg  [8:0] osc_div,
    output wire       switching
);

    // the gap count is worked out as an integer, then cut to the counter
    localparam integer GAP_N = `PCS_SWITCH_GAP_CYCLES;
    localparam [7:0]   GAP   = GAP_N[7:0];

    reg [2:0] cur_q;
    reg [7:0] gap_q;
    reg       busy_q;

    assign switching = busy_q;

    // the old enable falls first, the new one rises only after the gap,
    // so the downstream gate never sees two clocks at once
    always @(posedge clk) begin
        if (rst) begin
            cur_q   <= `PCS_SRC_OSC;
            gap_q   <= 8'h00;
            busy_q  <= 1'b0;
            src_en  <= 3'b001;
            osc_div <= 9'h001;
        end else if (!busy_q && req_src != cur_q) begin
            src_en <= 3'b000;
            busy_q <= 1'b1;
            gap_q  <= GAP;
        end else if (busy_q) begin
            if (gap_q > 8'h01) begin
                gap_q <= gap_q - 8'h01;
            end else begin
                busy_q <= 1'b0;
                cur_q  <= req_src;
                case (req_src)
                    `PCS_SRC_EXT: begin
                        src_en  <= 3'b010;
                        osc_div <= 9'h001;
                    end
                    `PCS_SRC_PLL: begin
                        src_en  <= 3'b100;
                        osc_div <= 9'h001;
                    end
                    `PCS_SRC_OSC_DIV8: begin
                        src_en  <= 3'b001;
                        osc_div <= 9'h008;
                    end
                    `PCS_SRC_OSC_DIV16: begin
                        src_en  <= 3'b001;
                        osc_div <= 9'h010;
                    end
                    `PCS_SRC_OSC_DIV32: begin
                        src_en  <= 3'b001;
                        osc_div <= 9'h020;
                    end
                    `PCS_SRC_OSC_DIV64: begin
                        src_en  <= 3'b001;
                        osc_div <= 9'h040;
                    end
                    `PCS_SRC_OSC_DIV256: begin
                        src_en  <= 3'b001;
                        osc_div <= 9'h100;
                    end
                    default: begin
                        src_en  <= 3'b001;
                        osc_div <= 9'h001;
                    end
                endcase
            end
        end
    end

endmodule // pcs_srcsw

// File: logic/pcs_top.v
// clock source, pll setup commit, boot clock and program memory sleep
`timescale 1ns/1ns
`include "pcs_map.vh"
module pcs_top #(
    parameter PROG_WORDS = 4096,
    parameter AW         = 12,
    parameter DW         = 8
) (
    // clock and reset
    input  wire          CLK,
    input  wire          RST,
    // special-function register port
    input  wire [7:0]    SFR_ADDR,
    input  wire [7:0]    SFR_WDATA,
    input  wire          SFR_WR,
    input  wire          SFR_RD,
    output reg  [7:0]    SFR_RDATA,
    // boot strap pin
    input  wire          BOOT_CLOCK_STRAP_PIN,
    // clock generator controls
    output wire [2:0]    SRC_EN,
    output wire [8:0]    OSC_DIV,
    output wire          SRC_SWITCHING,
    output wire          REF_IS_EXT,
    output wire [11:0]   PLL_MULTIPLIER,
    output wire [9:0]    PLL_REF_DIVISOR,
    output wire [3:0]    LOCK_RANGE_ONE,
    output wire          CORE_CLK_SAME_AS_SYS,
    // boot copy
    output reg  [AW-1:0] NVM_ADDR,
    input  wire [DW-1:0] NVM_RDATA,
    output reg  [AW-1:0] RAM_ADDR,
    output reg  [DW-1:0] RAM_WDATA,
    output reg           RAM_WE,
    output wire          RESET_PIN_O,
    output wire          RESET_PIN_OE,
    output wire          BOOT_ACTIVE,
    // program memory and core
    output wire          PROG_MEM_EN,
    output wire          CORE_STALL
);

    localparam [1:0] SL_SLEEP = 2'h0;
    localparam [1:0] SL_SETUP = 2'h1;
    localparam [1:0] SL_RUN   = 2'h2;

    localparam [1:0] BT_STRAP = 2'h0;
    localparam [1:0] BT_COPY  = 2'h1;
    localparam [1:0] BT_LAST  = 2'h2;
    localparam [1:0] BT_DONE  = 2'h3;

    reg [7:0]  sleep_cycle_count_q;
    reg [7:0]  wake_cycle_count_q;
    reg [7:0]  pll_setup_byte0_q;
    reg [7:0]  pll_setup_byte1_q;
    reg [7:0]  pll_setup_byte2_q;
    reg [7:0]  pll_setup_byte3_q;
    reg [7:0]  pll_setup_commit_byte_q;
    reg [39:0] active_q;
    reg        committed_q;
    reg        strap_s1_q;
    reg        strap_s2_q;
    reg        strap_q;
    reg [1:0]  boot_q;
    reg [1:0]  slp_q;
    reg [11:0] slp_cnt_q;
    reg        sleep_kick;
    wire       wr_commit;
    wire [2:0] req_src;
    wire [2:0] src_field;
    wire [1:0] ref_div;
    wire [3:0] wake_setup;

    assign wr_commit  = SFR_WR && SFR_ADDR == `PCS_PLL_SETUP_COMMIT_ADDR;
    assign wake_setup = pll_setup_byte3_q[`PCS_WAKE_SETUP_MSB:
                                          `PCS_WAKE_SETUP_LSB];

    // register writes; the sleep and wake counts and the byte 3 wake-setup bits
    // act at once, the other setup bits wait in the shadow bytes for the commit
    always @(posedge CLK) begin
        if (RST) begin
            sleep_cycle_count_q     <= `PCS_SLEEP_CYCLE_COUNT_RST;
            wake_cycle_count_q      <= `PCS_WAKE_CYCLE_COUNT_RST;
            pll_setup_byte0_q       <= `PCS_PLL_BYTE_RST;
            pll_setup_byte1_q       <= `PCS_PLL_BYTE_RST;
            pll_setup_byte2_q       <= `PCS_PLL_BYTE_RST;
            pll_setup_byte3_q       <= `PCS_PLL_BYTE_RST;
            pll_setup_commit_byte_q <= `PCS_PLL_BYTE_RST;
        end else if (SFR_WR) begin
            case (SFR_ADDR)
                `PCS_SLEEP_CYCLE_COUNT_ADDR:
                    sleep_cycle_count_q <= SFR_WDATA;
                `PCS_WAKE_CYCLE_COUNT_ADDR:
                    wake_cycle_count_q <= SFR_WDATA;
                `PCS_PLL_SETUP_BYTE0_ADDR:
                    pll_setup_byte0_q <= SFR_WDATA;
                `PCS_PLL_SETUP_BYTE1_ADDR:
                    pll_setup_byte1_q <= SFR_WDATA;
                `PCS_PLL_SETUP_BYTE2_ADDR:
                    pll_setup_byte2_q <= SFR_WDATA;
                `PCS_PLL_SETUP_BYTE3_ADDR:
                    pll_setup_byte3_q <= SFR_WDATA;
                `PCS_PLL_SETUP_COMMIT_ADDR:
                    pll_setup_commit_byte_q <= SFR_WDATA;
                default: ;
            endcase
        end
    end

    // all forty bits move together; the commit byte comes from the bus
    // in the same cycle, the lower bytes from earlier writes
    always @(posedge CLK) begin
        if (RST) begin
            active_q    <= 40'h00_0000_0000;
            committed_q <= 1'b0;
        end else if (wr_commit) begin
            active_q    <= {SFR_WDATA, pll_setup_byte3_q,
                            pll_setup_byte2_q, pll_setup_byte1_q,
                            pll_setup_byte0_q};
            committed_q <= 1'b1;
        end
    end

    // register reads, one cycle after the strobe
    always @(posedge CLK) begin
        if (RST) begin
            SFR_RDATA <= 8'h00;
        end else if (SFR_RD) begin
            case (SFR_ADDR)
                `PCS_SLEEP_CYCLE_COUNT_ADDR:
                    SFR_RDATA <= sleep_cycle_count_q;
                `PCS_WAKE_CYCLE_COUNT_ADDR:
                    SFR_RDATA <= wake_cycle_count_q;
                `PCS_PLL_SETUP_BYTE0_ADDR:
                    SFR_RDATA <= pll_setup_byte0_q;
                `PCS_PLL_SETUP_BYTE1_ADDR:
                    SFR_RDATA <= pll_setup_byte1_q;
                `PCS_PLL_SETUP_BYTE2_ADDR:
                    SFR_RDATA <= pll_setup_byte2_q;
                `PCS_PLL_SETUP_BYTE3_ADDR:
                    SFR_RDATA <= pll_setup_byte3_q;
                `PCS_PLL_SETUP_COMMIT_ADDR:
                    SFR_RDATA <= pll_setup_commit_byte_q;
                `PCS_CLOCK_STATUS_ADDR:
                    SFR_RDATA <= {1'b0, committed_q, SRC_SWITCHING,
                                  BOOT_ACTIVE, strap_q, PROG_MEM_EN,
                                  slp_q};
                default:
                    SFR_RDATA <= 8'h00;
            endcase
        end
    end

    // strap pin crosses in through two flops before anything reads it;
    // they run through reset, so the pin is settled when reset lifts
    always @(posedge CLK) begin
        strap_s1_q <= BOOT_CLOCK_STRAP_PIN;
        strap_s2_q <= strap_s1_q;
    end

    // boot sequence: catch the strap once after release, copy the
    // engine program, then let the user program start
    always @(posedge CLK) begin
        if (RST) begin
            boot_q    <= BT_STRAP;
            strap_q   <= 1'b0;
            NVM_ADDR  <= {AW{1'b0}};
            RAM_ADDR  <= {AW{1'b0}};
            RAM_WDATA <= {DW{1'b0}};
            RAM_WE    <= 1'b0;
        end else begin
            RAM_WE <= 1'b0;
            case (boot_q)
                BT_STRAP: begin
                    strap_q  <= strap_s2_q;
                    NVM_ADDR <= {AW{1'b0}};
                    boot_q   <= BT_COPY;
                end
                BT_COPY: begin
                    // nvm answers in the same cycle as the address
                    RAM_ADDR  <= NVM_ADDR;
                    RAM_WDATA <= NVM_RDATA;
                    RAM_WE    <= 1'b1;
                    if (NVM_ADDR == PROG_WORDS[AW-1:0] - 1'b1) begin
                        boot_q <= BT_LAST;
                    end else begin
                        NVM_ADDR <= NVM_ADDR + 1'b1;
                    end
                end
                BT_LAST: begin
                    boot_q <= BT_DONE;
                end
                default: begin
                    boot_q <= BT_DONE;
                end
            endcase
        end
    end

    assign BOOT_ACTIVE  = boot_q != BT_DONE;
    // reset pin is pulled low for the whole boot copy
    assign RESET_PIN_O  = 1'b0;
    assign RESET_PIN_OE = BOOT_ACTIVE;

    // the strap choice holds until the first commit, then the setup wins
    assign src_field = active_q[`PCS_SRC_SEL_MSB:`PCS_SRC_SEL_LSB];
    assign req_src   = committed_q ? src_field :
                       (strap_q ? `PCS_SRC_EXT : `PCS_SRC_OSC);

    // before commit the reference follows the strap, afterwards the
    // reference select bit in byte 3
    assign REF_IS_EXT = committed_q ? ~active_q[24] : strap_q;

    // engine and core clocks stay locked together until a commit
    assign CORE_CLK_SAME_AS_SYS = ~committed_q;

    // divisor seen by the pll; bypass forces one
    assign ref_div = active_q[`PCS_REF_DIV_MSB:`PCS_REF_DIV_LSB];
    assign PLL_REF_DIVISOR =
        active_q[`PCS_DIV_BYPASS_BIT] ? 10'h001 :
        (10'h200 >> ref_div);
    assign PLL_MULTIPLIER = active_q[`PCS_MULT_MSB:`PCS_MULT_LSB];
    // passed through as written; the value itself is software's job
    assign LOCK_RANGE_ONE =
        active_q[`PCS_LOCK_RANGE_ONE_MSB:`PCS_LOCK_RANGE_ONE_LSB];

    pcs_srcsw u_srcsw (
        .clk       (CLK),
        .rst       (RST),
        .req_src   (req_src),
        .src_en    (SRC_EN),
        .osc_div   (OSC_DIV),
        .switching (SRC_SWITCHING)
    );

    // a sleep-count write restarts sleep at once, whatever the state
    always @* begin
        sleep_kick = SFR_WR && SFR_ADDR == `PCS_SLEEP_CYCLE_COUNT_ADDR;
    end

    // sleep / setup / run cycle of the program memory; the counter
    // holds the cycles still to go in the current phase
    always @(posedge CLK) begin
        if (RST) begin
            slp_q     <= SL_SLEEP;
            slp_cnt_q <= 12'h000;
        end else if (sleep_kick) begin
            slp_q     <= SL_SLEEP;
            slp_cnt_q <= {SFR_WDATA, 4'h0};
        end else begin
            case (slp_q)
                SL_SLEEP: begin
                    if (slp_cnt_q > 12'h001) begin
                        slp_cnt_q <= slp_cnt_q - 12'h001;
                    end else if (wake_setup != 4'h0) begin
                        slp_q     <= SL_SETUP;
                        slp_cnt_q <= {8'h00, wake_setup};
                    end else begin
                        slp_q     <= SL_RUN;
                        slp_cnt_q <= {4'h0, wake_cycle_count_q};
                    end
                end
                SL_SETUP: begin
                    if (slp_cnt_q > 12'h001) begin
                        slp_cnt_q <= slp_cnt_q - 12'h001;
                    end else begin
                        slp_q     <= SL_RUN;
                        slp_cnt_q <= {4'h0, wake_cycle_count_q};
                    end
                end
                SL_RUN: begin
                    // zero wake count means stay awake for good
                    if (wake_cycle_count_q == 8'h00) begin
                        slp_cnt_q <= 12'h000;
                    end else if (slp_cnt_q > 12'h001) begin
                        slp_cnt_q <= slp_cnt_q - 12'h001;
                    end else begin
                        slp_q     <= SL_SLEEP;
                        slp_cnt_q <= {sleep_cycle_count_q, 4'h0};
                    end
                end
                default: begin
                    slp_q     <= SL_SLEEP;
                    slp_cnt_q <= 12'h000;
                end
            endcase
        end
    end

    // memory is powered in setup and run; the core only fetches in run
    assign PROG_MEM_EN = slp_q != SL_SLEEP;
    assign CORE_STALL  = slp_q != SL_RUN;

endmodule // pcs_top

// File: test/pcs_monitor.sv
// checker for source switching, setup commit, boot and sleep timing
`timescale 1ns/1ns
module pcs_monitor (
    // clock and reset
    input wire        CLK,
    input wire        RST,
    // register port
    input wire [7:0]  SFR_ADDR,
    input wire [7:0]  SFR_WDATA,
    input wire        SFR_WR,
    // clock generator
    input wire [2:0]  SRC_EN,
    input wire [11:0] PLL_MULTIPLIER,
    input wire [3:0]  LOCK_RANGE_ONE,
    input wire        CORE_CLK_SAME_AS_SYS,
    // boot and memory
    input wire        RAM_WE,
    input wire        RESET_PIN_O,
    input wire        RESET_PIN_OE,
    input wire        BOOT_ACTIVE,
    input wire        PROG_MEM_EN,
    input wire        CORE_STALL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // sleep and enable relations
    a_stall_when_asleep: assert property (!PROG_MEM_EN |-> CORE_STALL)
        else $error("core runs while memory sleeps");
    a_asleep_from_reset: assert property ($fell(RST) |-> !PROG_MEM_EN)
        else $error("memory awake at reset release");
    a_sleep_entry: assert property (
        SFR_WR && SFR_ADDR == 8'hC4 |=> !PROG_MEM_EN)
        else $error("sleep write did not drop memory enable");
    a_sleep_two_len: assert property (SFR_WR && SFR_ADDR == 8'hC4 &&
        SFR_WDATA == 8'h02 |-> ##32 !PROG_MEM_EN ##1 PROG_MEM_EN)
        else $error("sleep of 2 did not last 32 cycles");
    // setup word is applied only by the commit byte
    a_commit_applies: assert property (SFR_WR && SFR_ADDR == 8'hDD
        |=> !CORE_CLK_SAME_AS_SYS) else $error("commit not applied");
    a_setup_held: assert property (SFR_WR && SFR_ADDR != 8'hDD |=>
        $stable(PLL_MULTIPLIER) && $stable(LOCK_RANGE_ONE))
        else $error("setup changed without commit");
    // break before make on the source enables
    a_src_onehot: assert property ($onehot0(SRC_EN))
        else $error("two sources enabled");
    a_gap_length: assert property ($fell(|SRC_EN) |->
        (SRC_EN == 3'b000) [*4] ##1 (SRC_EN != 3'b000))
        else $error("switch gap not four cycles");
    a_break_first: assert property ($changed(SRC_EN) &&
        $past(SRC_EN) != 3'b000 |-> SRC_EN == 3'b000)
        else $error("source switched without gap");
    // boot copy holds the reset pin low
    a_reset_pin_low: assert property (RESET_PIN_OE == BOOT_ACTIVE &&
        !RESET_PIN_O) else $error("reset pin not driven low in boot");
    a_copy_in_boot: assert property (RAM_WE |-> BOOT_ACTIVE)
        else $error("program ram written after boot");
    a_boot_shared: assert property (
        BOOT_ACTIVE |-> CORE_CLK_SAME_AS_SYS)
        else $error("core clock differs during boot");
    c_commit: cover property (SFR_WR && SFR_ADDR == 8'hDD);
    c_sleep: cover property (SFR_WR && SFR_ADDR == 8'hC4);
    c_copy: cover property (RAM_WE);
    c_gap: cover property ($fell(|SRC_EN));
endmodule // pcs_monitor

// File: test/pcs_top_tb_top.sv
// testbench for clock select, setup commit, boot copy and sleep timer
`timescale 1ns/1ns
`include "pcs_map.vh"
module pcs_top_tb_top;
    localparam int WORDS = 16;
    // stimulus and observed signals
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  SFR_ADDR = 8'h00;
    logic [7:0]  SFR_WDATA = 8'h00;
    logic        SFR_WR = 1'b0;
    logic        SFR_RD = 1'b0;
    logic        BOOT_CLOCK_STRAP_PIN = 1'b0;
    wire  [7:0]  SFR_RDATA, NVM_RDATA, RAM_WDATA;
    wire  [2:0]  SRC_EN;
    wire  [8:0]  OSC_DIV;
    wire  [11:0] PLL_MULTIPLIER, NVM_ADDR, RAM_ADDR;
    wire  [9:0]  PLL_REF_DIVISOR;
    wire  [3:0]  LOCK_RANGE_ONE;
    wire         SRC_SWITCHING, REF_IS_EXT, CORE_CLK_SAME_AS_SYS, RAM_WE;
    wire         RESET_PIN_O, RESET_PIN_OE, BOOT_ACTIVE;
    wire         PROG_MEM_EN, CORE_STALL;
    int          failures = 0;
    int          samples_checked = 0;
    int          words = 0;
    int          i;
    logic [31:0] rng = 32'h752F;
    logic [11:0] prev_mult = 12'h000;
    logic [2:0]  prev_src = 3'h0;

    always #4 CLK = ~CLK;

    pcs_top #(.PROG_WORDS(WORDS)) u_dut (
        .CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
        .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
        .BOOT_CLOCK_STRAP_PIN(BOOT_CLOCK_STRAP_PIN), .SRC_EN(SRC_EN),
        .OSC_DIV(OSC_DIV), .SRC_SWITCHING(SRC_SWITCHING),
        .REF_IS_EXT(REF_IS_EXT), .PLL_MULTIPLIER(PLL_MULTIPLIER),
        .PLL_REF_DIVISOR(PLL_REF_DIVISOR), .LOCK_RANGE_ONE(LOCK_RANGE_ONE),
        .CORE_CLK_SAME_AS_SYS(CORE_CLK_SAME_AS_SYS), .NVM_ADDR(NVM_ADDR),
        .NVM_RDATA(NVM_RDATA), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
        .RAM_WE(RAM_WE), .RESET_PIN_O(RESET_PIN_O),
        .RESET_PIN_OE(RESET_PIN_OE), .BOOT_ACTIVE(BOOT_ACTIVE),
        .PROG_MEM_EN(PROG_MEM_EN), .CORE_STALL(CORE_STALL));

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic logic [7:0] nvm_val(input logic [11:0] a);
        return a[7:0] * 8'h3B ^ 8'hA5;
    endfunction
    // non-volatile memory answers within the cycle of its address
    assign NVM_RDATA = nvm_val(NVM_ADDR);

    task automatic check_v(input string what, input logic [11:0] e,
                           input logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic check_n(input string what, input int e, input int g);
        samples_checked++;
        if (g != e) begin
            failures++;
            $display("unexpected %s: expected %0d, seen %0d", what, e, g);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // copy traffic is sampled mid-cycle, away from the updating edge
    always @(negedge CLK) begin
        if (!RST && RAM_WE === 1'b1) begin
            check_v("ram data", nvm_val(RAM_ADDR), RAM_WDATA);
            check_v("ram addr", words, RAM_ADDR);
            words++;
        end
    end

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        SFR_WR <= 1'b1;
        @(posedge CLK);
        SFR_WR <= 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK);
        SFR_ADDR <= a;
        SFR_RD <= 1'b1;
        @(posedge CLK);
        SFR_RD <= 1'b0;
        #1;
        check_v("read data", e, SFR_RDATA);
    endtask
    task automatic do_reset(input logic strap);
        int n;
        @(posedge CLK);
        RST <= 1'b1;
        BOOT_CLOCK_STRAP_PIN <= strap;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        words = 0;
        prev_mult = 12'h000;
        prev_src = strap ? 3'h1 : 3'h0;
        for (n = 0; n < 60 && BOOT_ACTIVE !== 1'b0; n++) @(posedge CLK);
        #1;
        check_n("boot words", WORDS, words);
        check_v("boot source", strap ? 3'b010 : 3'b001, SRC_EN);
        check_v("shared clock", 1'b1, CORE_CLK_SAME_AS_SYS);
    endtask
    // all five bytes, the commit byte last; outputs wait for it
    task automatic commit(input logic [2:0] src);
        logic [31:0] r;
        logic [11:0] m;
        r = xs();
        m = 12'(768 + r % 3319);
        sfr_wr(`PCS_PLL_SETUP_BYTE0_ADDR, m[7:0]);
        sfr_wr(`PCS_PLL_SETUP_BYTE1_ADDR, {4'h1, m[11:8]});
        sfr_wr(`PCS_PLL_SETUP_BYTE2_ADDR, {r[20], 4'h0, src});
        sfr_wr(`PCS_PLL_SETUP_BYTE3_ADDR, {7'h00, r[23]});
        #1;
        check_v("held mult", prev_mult, PLL_MULTIPLIER);
        sfr_wr(`PCS_PLL_SETUP_COMMIT_ADDR, {6'h00, r[22:21]});
        @(posedge CLK);
        #1;
        check_v("mult", m, PLL_MULTIPLIER);
        check_v("lock range", 4'h1, LOCK_RANGE_ONE);
        check_v("ref div", r[20] ? 10'd1 : 10'd512 >> r[22:21],
                PLL_REF_DIVISOR);
        check_v("ref ext", !r[23], REF_IS_EXT);
        check_v("switching", src != prev_src, SRC_SWITCHING);
        prev_mult = m;
        repeat (6) @(posedge CLK);
        #1;
        check_v("src en", src == 1 ? 3'b010 : src == 2 ? 3'b100 : 3'b001,
                SRC_EN);
        check_v("switch done", 1'b0, SRC_SWITCHING);
        prev_src = src;
        if (src == 0 || src > 2)
            check_v("osc div", src == 0 ? 1 : 1 << (src == 7 ? 8 : src),
                    OSC_DIV);
    endtask
    // records state segments and compares them with sleep, setup, run
    task automatic sleep_run(input int n, input int w, input int k);
        int len[$];
        logic [1:0] kd[$];
        int el[$];
        logic [1:0] ek[$];
        logic [1:0] s;
        int p;
        sfr_wr(`PCS_PLL_SETUP_BYTE3_ADDR, {1'b0, 4'(w), 3'b000});
        sfr_wr(`PCS_WAKE_CYCLE_COUNT_ADDR, 8'(k));
        sfr_wr(`PCS_SLEEP_CYCLE_COUNT_ADDR, 8'(n));
        for (p = 0; p < ((k == 0) ? 1 : 2); p++) begin
            el.push_back((n == 0) ? 1 : n * 16);
            ek.push_back(2'b01);
            if (w != 0) el.push_back(w);
            if (w != 0) ek.push_back(2'b11);
            el.push_back(k);
            ek.push_back(2'b10);
        end
        // the first sample is the cycle right after the sleep write edge
        repeat (2 * (n * 16 + w + k) + 8) begin
            #1;
            s = {PROG_MEM_EN, CORE_STALL};
            if (kd.size() > 0 && kd[$] === s) len[$]++;
            else begin
                len.push_back(1);
                kd.push_back(s);
            end
            @(posedge CLK);
        end
        check_n("segments", el.size() + (k != 0), len.size());
        for (p = 0; p < el.size() && p < kd.size(); p++) begin
            check_v("state", ek[p], kd[p]);
            if (p < len.size() - 1)
                check_n("length", el[p], len[p]);
        end
    endtask

    initial begin
        #(8 * 40000);
        failures++;
        end_sim();
    end

    initial begin
        do_reset(1'b0);
        // status after boot: nothing committed, memory awake and running
        sfr_rd(`PCS_CLOCK_STATUS_ADDR, 8'h06);
        sfr_rd(`PCS_SLEEP_CYCLE_COUNT_ADDR, `PCS_SLEEP_CYCLE_COUNT_RST);
        sfr_rd(`PCS_WAKE_CYCLE_COUNT_ADDR, `PCS_WAKE_CYCLE_COUNT_RST);
        sfr_rd(`PCS_PLL_SETUP_BYTE3_ADDR, `PCS_PLL_BYTE_RST);
        sfr_wr(8'h10, 8'h5A);
        sfr_rd(8'h10, 8'h00);
        sfr_wr(`PCS_WAKE_CYCLE_COUNT_ADDR, 8'h3C);
        sfr_rd(`PCS_WAKE_CYCLE_COUNT_ADDR, 8'h3C);
        for (i = 0; i < 8; i++) commit(3'(i));
        sleep_run(0, 0, 0);
        sleep_run(2, 0, 0);
        sleep_run(1, 15, 1);
        sleep_run(3, 4, 0);
        repeat (5) sleep_run(1 + xs() % 5, xs() % 16, 1 + xs() % 40);
        // second reset in mid-run, booting from the external crystal
        do_reset(1'b1);
        @(posedge CLK);
        BOOT_CLOCK_STRAP_PIN <= 1'b0;
        repeat (10) @(posedge CLK);
        #1;
        check_v("strap held", 3'b010, SRC_EN);
        commit(3'b000);
        end_sim();
    end
endmodule // pcs_top_tb_top

bind pcs_top pcs_monitor u_mon (
    .CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR), .SRC_EN(SRC_EN), .PLL_MULTIPLIER(PLL_MULTIPLIER),
    .LOCK_RANGE_ONE(LOCK_RANGE_ONE),
    .CORE_CLK_SAME_AS_SYS(CORE_CLK_SAME_AS_SYS), .RAM_WE(RAM_WE),
    .RESET_PIN_O(RESET_PIN_O), .RESET_PIN_OE(RESET_PIN_OE),
    .BOOT_ACTIVE(BOOT_ACTIVE), .PROG_MEM_EN(PROG_MEM_EN),
    .CORE_STALL(CORE_STALL));
